// file: logic/dbgmb_pkg.sv
// Shared constants and carrier types for the debug mailbox and test-port gate.
// Assumes every user reaches these names as dbgmb_pkg::name, with no import.
package dbgmb_pkg;
  localparam int DATA_W = 8;
  localparam int DIRTY_BIT = 7;
  localparam logic [7:0] MAILBOX_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  // Fuse byte layout: a bit at one means the fuse is programmed.
  localparam int FUSE_DBG_EN_BIT = 7;
  localparam int FUSE_TP_EN_BIT = 6;
  localparam logic [7:0] FUSE_RESET = 8'h40;
  localparam int LOCK_W = 2;
  localparam logic [1:0] LOCK_RESET = 2'h0;

  typedef enum logic [1:0] {
    TGT_FLASH = 2'h0,
    TGT_EEPROM = 2'h1,
    TGT_FUSE = 2'h2,
    TGT_LOCK = 2'h3
  } dbgmb_target_t;

  typedef enum logic [1:0] {
    OP_PROG = 2'h0,
    OP_VERIFY = 2'h1,
    OP_ERASE = 2'h2,
    OP_NONE = 2'h3
  } dbgmb_op_t;

  // One programming command from the test port, valid for one cycle.
  typedef struct packed {
    logic valid;
    dbgmb_target_t target;
    dbgmb_op_t op;
    logic [7:0] data;
  } dbgmb_cmd_t;

  // One CPU access to the shared I/O address, strobes valid for one cycle.
  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } dbgmb_io_t;
endpackage

// file: logic/dbgmb_prog_gate.sv
// Test-port programming gate: holds fuse and lock bits, screens commands.
// Assumes commands arrive synchronous to the CPU clock from the TAP logic.
`timescale 1ns/10ps
`default_nettype none
module dbgmb_prog_gate #(
  parameter logic [7:0] FUSE_INIT = dbgmb_pkg::FUSE_RESET
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_tap_en,
  input wire dbgmb_pkg::dbgmb_cmd_t i_cmd,
  output logic [7:0] o_fuse_q,
  output logic [1:0] o_lock_q,
  output dbgmb_pkg::dbgmb_cmd_t o_mem_req,
  output logic o_verify_valid,
  output logic [7:0] o_verify_data,
  output logic o_refused
);
  wire acc = i_cmd.valid & i_tap_en;
  wire is_fuse = i_cmd.target == dbgmb_pkg::TGT_FUSE;
  wire is_lock = i_cmd.target == dbgmb_pkg::TGT_LOCK;
  wire is_prog = i_cmd.op == dbgmb_pkg::OP_PROG;
  wire is_verify = i_cmd.op == dbgmb_pkg::OP_VERIFY;
  wire is_erase = i_cmd.op == dbgmb_pkg::OP_ERASE;
  wire locked = |o_lock_q;
  wire dbg_fuse_new = i_cmd.data[dbgmb_pkg::FUSE_DBG_EN_BIT] &
                      ~o_fuse_q[dbgmb_pkg::FUSE_DBG_EN_BIT];
  // A locked part may not gain the debug fuse, else it leaks its content.
  wire fuse_blocked = acc & is_fuse & is_prog & locked & dbg_fuse_new;
  wire fuse_wr = acc & is_fuse & is_prog & ~fuse_blocked;
  wire lock_wr = acc & is_lock & is_prog;
  wire erase = acc & is_erase;
  wire local_verify = acc & is_verify & (is_fuse | is_lock);
  wire mem_fwd = erase |
                 (acc & ~is_fuse & ~is_lock & (is_prog | is_verify));
  wire nxt_refused = (i_cmd.valid & ~i_tap_en) | fuse_blocked;
  wire [7:0] nxt_fuse_q = fuse_wr ? i_cmd.data : o_fuse_q;
  // Lock bits only gain programmed bits; only a chip erase or a reset clears them.
  wire [1:0] nxt_lock_q = erase ? dbgmb_pkg::LOCK_RESET :
                          lock_wr ? (o_lock_q | i_cmd.data[1:0]) : o_lock_q;
  wire [7:0] nxt_verify_data = is_fuse ? o_fuse_q : {6'h00, o_lock_q};
  wire dbgmb_pkg::dbgmb_cmd_t nxt_mem_req = mem_fwd ? i_cmd : '0;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_fuse_q <= FUSE_INIT;
      o_lock_q <= dbgmb_pkg::LOCK_RESET;
      o_mem_req <= '0;
      o_verify_valid <= 1'b0;
      o_verify_data <= 8'h00;
      o_refused <= 1'b0;
    end else begin
      o_fuse_q <= nxt_fuse_q;
      o_lock_q <= nxt_lock_q;
      o_mem_req <= nxt_mem_req;
      o_verify_valid <= local_verify;
      o_verify_data <= local_verify ? nxt_verify_data : o_verify_data;
      o_refused <= nxt_refused;
    end
  end

  sequence s_locked_dbg_prog;
    i_cmd.valid && i_tap_en && is_fuse && is_prog && (|o_lock_q) &&
      i_cmd.data[dbgmb_pkg::FUSE_DBG_EN_BIT] &&
      !o_fuse_q[dbgmb_pkg::FUSE_DBG_EN_BIT];
  endsequence

  chk_tap_gated_cmd: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_cmd.valid && !i_tap_en |=> o_refused && !o_mem_req.valid &&
      $stable(o_fuse_q) && $stable(o_lock_q))
    else $error("Command taken while the test port was off.");

  chk_mem_forward: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_cmd.valid && i_tap_en && !is_fuse && !is_lock && is_prog |=>
      o_mem_req.valid && o_mem_req.data == $past(i_cmd.data))
    else $error("Flash or EEPROM command was not forwarded.");

  chk_locked_fuse: assert property (
    @(posedge i_clk) disable iff (i_rst)
    s_locked_dbg_prog |=> o_refused &&
      !o_fuse_q[dbgmb_pkg::FUSE_DBG_EN_BIT] ##1
      !o_fuse_q[dbgmb_pkg::FUSE_DBG_EN_BIT])
    else $error("Debug fuse programmed on a locked part.");

  chk_erase_unlock: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_cmd.valid && i_tap_en && is_erase |=> o_lock_q == 2'h0)
    else $error("Chip erase did not clear the lock bits.");
endmodule
`default_nettype wire

// file: logic/dbgmb_top.sv
// Debug mailbox on a shared CPU I/O address, test-port enable and fuse gate.
// Assumes CPU strobes, debugger controls and commands are on the CPU clock.
//
// Overview of operation
// - A CPU write stores its byte for the external debugger to read.
// - That CPU write also sets the dirty flag for the debugger.
// - A CPU read returns the dirty flag on bit 7, stored bits below.
// - Shared address reaches mailbox only with debug fuse and debugger on.
// - Test port is on only with its fuse programmed and disable bit zero.
// - Test port programs and verifies flash, EEPROM, fuses and lock bits.
// - A set lock bit blocks debug fuse programming until chip erase or reset.
`timescale 1ns/10ps
`default_nettype none
module dbgmb_top #(
  parameter logic SHARED_ADDR = 1'b1,
  parameter logic [7:0] FUSE_INIT = dbgmb_pkg::FUSE_RESET
) (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire dbgmb_pkg::dbgmb_io_t I_IO,
  input wire logic I_DBG_ACC_EN,
  input wire logic I_DBG_CLR,
  input wire logic I_TP_DISABLE_BIT,
  input wire dbgmb_pkg::dbgmb_cmd_t I_CMD,
  output logic [7:0] O_IO_RDATA,
  output logic O_STD_WR,
  output logic O_STD_RD,
  output logic [7:0] O_STD_WDATA,
  output logic [7:0] O_DBG_DATA,
  output logic O_DBG_DIRTY,
  output logic O_TAP_EN,
  output logic [7:0] O_FUSE,
  output logic [1:0] O_LOCK,
  output dbgmb_pkg::dbgmb_cmd_t O_MEM_REQ,
  output logic O_VERIFY_VALID,
  output logic [7:0] O_VERIFY_DATA,
  output logic O_PROG_REFUSED
);
  logic [7:0] debug_mailbox_ff;
  logic debug_data_dirty_flag_ff;
  logic [7:0] rdata_ff;
  logic std_wr_ff;
  logic std_rd_ff;
  logic [7:0] std_wdata_ff;
  logic tap_en_ff;
  logic [7:0] fuse_q;
  logic [1:0] lock_q;

  // The fuse and lock store sits in the gate so that a locked check never
  // sees a lock write still in flight.
  dbgmb_prog_gate #(
    .FUSE_INIT(FUSE_INIT)
  ) u_gate (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_tap_en(tap_en_ff),
    .i_cmd(I_CMD),
    .o_fuse_q(fuse_q),
    .o_lock_q(lock_q),
    .o_mem_req(O_MEM_REQ),
    .o_verify_valid(O_VERIFY_VALID),
    .o_verify_data(O_VERIFY_DATA),
    .o_refused(O_PROG_REFUSED)
  );

  wire debug_enable_fuse = fuse_q[dbgmb_pkg::FUSE_DBG_EN_BIT];
  wire test_port_enable_fuse = fuse_q[dbgmb_pkg::FUSE_TP_EN_BIT];
  // Without a shared address the mailbox owns the location outright.
  wire mb_route = SHARED_ADDR ?
                  (debug_enable_fuse & I_DBG_ACC_EN) : 1'b1;
  wire mb_wr = I_IO.sel & I_IO.wr & mb_route;
  wire mb_rd = I_IO.sel & I_IO.rd & mb_route;
  wire std_wr = I_IO.sel & I_IO.wr & ~mb_route;
  wire std_rd = I_IO.sel & I_IO.rd & ~mb_route;
  // Unread data is overwritten with no error; software must pace itself.
  wire [7:0] nxt_debug_mailbox =
    mb_wr ? I_IO.wdata : debug_mailbox_ff;
  // A write in the cycle of a debugger clear wins, so no byte goes unseen.
  wire nxt_debug_data_dirty_flag = mb_wr |
                                   (debug_data_dirty_flag_ff & ~I_DBG_CLR);
  wire [7:0] read_word =
    {debug_data_dirty_flag_ff, debug_mailbox_ff[6:0]};
  wire [7:0] nxt_rdata = mb_rd ? read_word : rdata_ff;
  wire [7:0] nxt_std_wdata = std_wr ? I_IO.wdata : std_wdata_ff;
  wire nxt_tap_en = test_port_enable_fuse & ~I_TP_DISABLE_BIT;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      debug_mailbox_ff <= dbgmb_pkg::MAILBOX_RESET;
      debug_data_dirty_flag_ff <= 1'b0;
      rdata_ff <= dbgmb_pkg::RDATA_RESET;
      std_wr_ff <= 1'b0;
      std_rd_ff <= 1'b0;
      std_wdata_ff <= 8'h00;
      tap_en_ff <= 1'b0;
    end else begin
      debug_mailbox_ff <= nxt_debug_mailbox;
      debug_data_dirty_flag_ff <= nxt_debug_data_dirty_flag;
      rdata_ff <= nxt_rdata;
      std_wr_ff <= std_wr;
      std_rd_ff <= std_rd;
      std_wdata_ff <= nxt_std_wdata;
      tap_en_ff <= nxt_tap_en;
    end
  end

  assign O_IO_RDATA = rdata_ff;
  assign O_STD_WR = std_wr_ff;
  assign O_STD_RD = std_rd_ff;
  assign O_STD_WDATA = std_wdata_ff;
  assign O_DBG_DATA = debug_mailbox_ff;
  assign O_DBG_DIRTY = debug_data_dirty_flag_ff;
  assign O_TAP_EN = tap_en_ff;
  assign O_FUSE = fuse_q;
  assign O_LOCK = lock_q;

  sequence s_mb_write;
    I_IO.sel && I_IO.wr && mb_route;
  endsequence

  sequence s_mb_read;
    I_IO.sel && I_IO.rd && mb_route;
  endsequence

  sequence s_std_write;
    I_IO.sel && I_IO.wr && !mb_route;
  endsequence

  sequence s_std_read;
    I_IO.sel && I_IO.rd && !mb_route;
  endsequence

  sequence s_clr_with_write;
    I_DBG_CLR && I_IO.sel && I_IO.wr && mb_route;
  endsequence

  chk_mailbox_data: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    s_mb_write |=> O_DBG_DATA == $past(I_IO.wdata))
    else $error("Mailbox byte not passed to the debugger.");

  chk_dirty_set: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    s_mb_write |=> O_DBG_DIRTY)
    else $error("Mailbox write did not set the dirty flag.");

  chk_read_format: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    s_mb_read |=> O_IO_RDATA ==
      {$past(O_DBG_DIRTY), $past(debug_mailbox_ff[6:0])})
    else $error("Mailbox read word is malformed.");

  chk_dirty_clear: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    O_DBG_DIRTY && I_DBG_CLR && !mb_wr |=> !O_DBG_DIRTY)
    else $error("Debugger clear did not drop the dirty flag.");

  chk_std_route: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    s_std_write |=> O_STD_WR && $stable(O_DBG_DATA) &&
      O_STD_WDATA == $past(I_IO.wdata))
    else $error("Ordinary I/O write reached the mailbox.");

  chk_route_gate: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    SHARED_ADDR && I_IO.sel && I_IO.wr &&
      !(debug_enable_fuse && I_DBG_ACC_EN) |=> O_STD_WR)
    else $error("Mailbox reached without fuse and debugger enable.");

  chk_tap_enable: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    !$past(I_SYS_RST) |-> O_TAP_EN ==
      ($past(test_port_enable_fuse) && !$past(I_TP_DISABLE_BIT)))
    else $error("Test port enable does not follow fuse and disable bit.");

  chk_overwrite: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    O_DBG_DIRTY ##0 s_mb_write |=> O_DBG_DIRTY &&
      O_DBG_DATA == $past(I_IO.wdata))
    else $error("Overwrite of unread data misbehaved.");

  chk_set_wins: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    s_clr_with_write |=> O_DBG_DIRTY && O_DBG_DATA == $past(I_IO.wdata))
    else $error("Debugger clear beat a same-cycle mailbox write.");

  chk_dirty_hold: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    !mb_wr && !I_DBG_CLR |=> O_DBG_DIRTY == $past(O_DBG_DIRTY))
    else $error("Dirty flag moved without a write or a clear.");

  chk_mailbox_hold: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    !mb_wr |=> $stable(O_DBG_DATA))
    else $error("Mailbox byte changed without a mailbox write.");

  chk_rdata_hold: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    !mb_rd |=> $stable(O_IO_RDATA))
    else $error("Read word changed without a mailbox read.");

  chk_std_read: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    s_std_read |=> O_STD_RD && $stable(O_IO_RDATA))
    else $error("Ordinary I/O read reached the mailbox.");

  chk_mb_quiet: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    I_IO.sel && mb_route |=> !O_STD_WR && !O_STD_RD)
    else $error("Mailbox access leaked to the ordinary location.");

  chk_std_idle: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    !I_IO.sel |=> !O_STD_WR && !O_STD_RD)
    else $error("Ordinary I/O strobe without a CPU access.");

  chk_read_gate: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    SHARED_ADDR && I_IO.sel && I_IO.rd &&
      !(debug_enable_fuse && I_DBG_ACC_EN) |=> O_STD_RD)
    else $error("Mailbox read without fuse and debugger enable.");

  chk_tap_off: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    I_TP_DISABLE_BIT |=> !O_TAP_EN)
    else $error("Test port stayed on with the disable bit set.");
endmodule
`default_nettype wire

// file: verification/dbgmb_debugger_model.sv
// Debugger model at the far side of the mailbox.
// Assumes the mailbox and dirty flag are registers on the CPU clock.
`timescale 1ns/10ps
`default_nettype none
module dbgmb_debugger_model (
  input wire logic i_clk,
  input wire logic i_en,
  input wire logic [3:0] i_wait,
  input wire logic i_dirty,
  input wire logic [7:0] i_data,
  output logic o_clr,
  output logic o_take,
  output logic [7:0] o_byte
);
  logic [3:0] cnt = 4'h0;
  initial begin
    o_clr = 1'b0;
    o_take = 1'b0;
    o_byte = 8'h00;
  end
  // The byte is held before the clear, so a slow poll loses nothing.
  always @(negedge i_clk) begin
    o_take <= 1'b0;
    o_clr <= 1'b0;
    if (!o_clr && i_en && i_dirty) begin
      if (cnt >= i_wait) begin
        o_byte <= i_data;
        o_take <= 1'b1;
        o_clr <= 1'b1;
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end else begin
      cnt <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// file: verification/test_debug_mailbox_and_tap_enable.sv
// Self-checking bench for the debug mailbox and test-port gate.
// Assumes the design's packages and modules are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module test_debug_mailbox_and_tap_enable;
  logic clk, rst, acc_en, tp_dis, dbg_en, std_wr, std_rd, dirty, tap_en;
  logic vvalid, refused, pclr, ptake;
  logic [3:0] dbg_wait;
  logic [7:0] io_rdata, std_wdata, dbg_data, fuse, vdata, pbyte, b;
  logic [1:0] lock;
  dbgmb_pkg::dbgmb_io_t io;
  dbgmb_pkg::dbgmb_cmd_t cm, mreq;
  logic [16:0] expq[$];
  logic [16:0] got;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h81e41dd1;
  logic [7:0] fuse_m = 8'h40;
  logic [1:0] lock_m = 2'h0;

  dbgmb_top dut (.I_CLK(clk), .I_SYS_RST(rst), .I_IO(io),
    .I_DBG_ACC_EN(acc_en), .I_DBG_CLR(pclr), .I_TP_DISABLE_BIT(tp_dis),
    .I_CMD(cm), .O_IO_RDATA(io_rdata), .O_STD_WR(std_wr), .O_STD_RD(std_rd),
    .O_STD_WDATA(std_wdata), .O_DBG_DATA(dbg_data), .O_DBG_DIRTY(dirty),
    .O_TAP_EN(tap_en), .O_FUSE(fuse), .O_LOCK(lock), .O_MEM_REQ(mreq),
    .O_VERIFY_VALID(vvalid), .O_VERIFY_DATA(vdata),
    .O_PROG_REFUSED(refused));
  dbgmb_debugger_model dbg (.i_clk(clk), .i_en(dbg_en), .i_wait(dbg_wait),
    .i_dirty(dirty), .i_data(dbg_data), .o_clr(pclr), .o_take(ptake),
    .o_byte(pbyte));

  function logic [7:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic check(input logic [16:0] g, input logic [16:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [7:0] d);
    @(negedge clk);
    io = '{sel:1'b1, wr:w, rd:!w, wdata:d};
    @(negedge clk);
    io = '0;
  endtask
  task automatic wr(input logic [7:0] d);
    if (!(fuse_m[7] && acc_en)) expq.push_back({4'h2, 5'h0, d});
    else if (dbg_en) expq.push_back({4'h1, 5'h0, d});
    acc(1'b1, d);
  endtask
  task automatic rd(input logic [7:0] e);
    if (!(fuse_m[7] && acc_en)) expq.push_back({4'h3, 13'h0});
    acc(1'b0, 8'h00);
    if (fuse_m[7] && acc_en) check({9'h0, io_rdata}, {9'h0, e});
  endtask
  task automatic drain;
    for (int i = 0; i < 40 && expq.size() > 0; i++) @(posedge clk);
    @(negedge clk);
    check({16'h0, expq.size() == 0}, 17'h1);
  endtask
  task automatic tap(input logic dis);
    @(negedge clk);
    tp_dis = dis;
    repeat (2) @(negedge clk);
    check({16'h0, tap_en}, {16'h0, fuse_m[6] & !dis});
  endtask
  // A small model of fuses and locks decides every command's outcome.
  task automatic cmd(input logic [1:0] t, o, input logic [7:0] d);
    @(negedge clk);
    cm = '{valid:1'b1, target:dbgmb_pkg::dbgmb_target_t'(t),
      op:dbgmb_pkg::dbgmb_op_t'(o), data:d};
    if (!(fuse_m[6] && !tp_dis)) expq.push_back({4'h5, 13'h0});
    else if (o == 2'h2 || (o != 2'h3 && !t[1])) begin
      expq.push_back({4'h6, cm});
      if (o == 2'h2) lock_m = 2'h0;
    end else if (o == 2'h1)
      expq.push_back({4'h4, 5'h0, t[0] ? {6'h0, lock_m} : fuse_m});
    else if (o == 2'h0 && t[0]) lock_m = lock_m | d[1:0];
    else if (o == 2'h0 && d[7] && !fuse_m[7] && lock_m != 2'h0)
      expq.push_back({4'h5, 13'h0});
    else if (o == 2'h0) fuse_m = d;
    @(negedge clk);
    cm = '0;
    repeat (2) @(negedge clk);
    check({1'b0, fuse, 6'h0, lock}, {1'b0, fuse_m, 6'h0, lock_m});
  endtask

  // Every strobe result takes the oldest note off the queue.
  always @(posedge clk) begin
    if ((ptake | std_wr | std_rd | vvalid | refused |
         mreq.valid) === 1'b1) begin
      got = ptake ? {4'h1, 5'h0, pbyte} : std_wr ? {4'h2, 5'h0, std_wdata} :
        std_rd ? {4'h3, 13'h0} : vvalid ? {4'h4, 5'h0, vdata} :
        refused ? {4'h5, 13'h0} : {4'h6, mreq};
      if (expq.size() == 0) check(got, 17'h0);
      else check(got, expq.pop_front());
    end
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #200000;
    error_cnt++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    final_report;
  end
  initial begin
    rst = 1'b1;
    acc_en = 1'b0;
    tp_dis = 1'b0;
    dbg_en = 1'b0;
    dbg_wait = 4'h0;
    io = '0;
    cm = '0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check({1'b0, fuse, dbg_data}, {1'b0, 8'h40, 8'h00});
    check({6'h0, lock, dirty, io_rdata}, 17'h0);
    tap(1'b1);
    cmd(2'h0, 2'h0, xorshift());
    tap(1'b0);
    acc_en = 1'b1;
    wr(xorshift());
    rd(8'h00);
    cmd(2'h2, 2'h0, 8'hc0);
    cmd(2'h2, 2'h1, 8'h00);
    acc_en = 1'b0;
    wr(xorshift());
    rd(8'h00);
    acc_en = 1'b1;
    wr(8'h5a);
    wr(8'ha5);
    rd(8'ha5);
    check({9'h0, dbg_data}, {9'h0, 8'ha5});
    dbg_en = 1'b1;
    expq.push_back({4'h1, 5'h0, 8'ha5});
    drain();
    rd(8'h25);
    for (int i = 0; i < 8; i++) begin
      dbg_wait = i[0] ? 4'h9 : 4'h0;
      b = xorshift();
      wr(b);
      drain();
    end
    // The debugger's clear lands on the second write's edge; the write wins.
    dbg_wait = 4'h1;
    wr(8'h3c);
    wr(8'hc3);
    check({16'h0, dirty}, 17'h1);
    drain();
    for (int i = 0; i < 6; i++) cmd(i[2:1] == 2'h0 ? 2'h0 : 2'h1,
      i[1:0] % 2'h3, xorshift());
    cmd(2'h3, 2'h0, 8'h01);
    cmd(2'h3, 2'h1, 8'h00);
    cmd(2'h2, 2'h0, 8'h40);
    cmd(2'h2, 2'h0, 8'hc0);
    cmd(2'h3, 2'h2, 8'h00);
    cmd(2'h2, 2'h0, 8'hc0);
    cmd(2'h2, 2'h3, 8'h00);
    drain();
    final_report;
  end
endmodule
`default_nettype wire
